// ### design/slm_core.sv
// safety logic matrix core: term pool, safety functions, drivers, encoders
// assumes APB master on pclk, encoder words synchronous to pclk
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "slm_consts.svh"
module slm_core #(
	parameter int TERMS         = `SLM_POOL_TERMS,
	parameter int TWO_HAND_CYC  = `SLM_TWO_HAND_MS * (`SLM_CLK_HZ / 1000),
	parameter int DISC_CYC      = `SLM_DISC_MS * (`SLM_CLK_HZ / 1000),
	parameter int SAMPLE_CYC    = `SLM_SAMPLE_US * (`SLM_CLK_HZ / 1000000),
	parameter int TP_PERIOD_CYC = `SLM_TP_PERIOD_US * (`SLM_CLK_HZ / 1000000)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [3:0]       din2_a,
	input  wire logic [3:0]       din2_b,
	input  wire logic [5:0]       din1,
	input  wire slm_pkg::slm_enc_s enc,
	output slm_pkg::slm_drv_s     drv,
	output logic                  quick_stop,
	output logic                  led_red,
	output logic                  led_green
);
	localparam int TPW_CYC = `SLM_TP_WIDTH_US * (`SLM_CLK_HZ / 1000000);
	localparam int NV = `SLM_NUM_VIRT;
	localparam int NL = `SLM_NUM_LOGIC_OUTPUT_SIGNAL;
	localparam logic [23:0] CMAX = 24'hFFFFFF;

	if (TERMS < 1 || TERMS > 32 || TWO_HAND_CYC < 1 || DISC_CYC < 1 ||
	    SAMPLE_CYC < 1 || TP_PERIOD_CYC <= TPW_CYC ||
	    TWO_HAND_CYC > 24'hFFFFFF || DISC_CYC > 24'hFFFFFF ||
	    SAMPLE_CYC > 24'hFFFFFF || TP_PERIOD_CYC > 24'hFFFFFF) begin : g_chk
		$error("slm_core: parameter out of range");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic pterm(input logic [31:0] m, input logic [31:0] iv,
		input logic [31:0] x);
		pterm = &(~m | (x ^ iv));
	endfunction : pterm

	function automatic logic [5:0] ones(input logic [31:0] x);
		ones = 6'h00;
		for (int i = 0; i < 32; i++) ones = ones + {5'h00, x[i]};
	endfunction : ones

	function automatic logic [15:0] mag(input logic [15:0] x);
		mag = x[15] ? 16'(-x) : x;
	endfunction : mag

	function automatic logic [23:0] sinc(input logic [23:0] c);
		sinc = (c == CMAX) ? c : 24'(c + 24'h000001);
	endfunction : sinc

	// base-unit angle only with a directly read partner
	function automatic logic pair_ok(input logic [5:0] c);
		logic [2:0] e1;
		logic [1:0] e2;
		e1 = c[2:0];
		e2 = c[5:4];
		case (e1)
			3'(slm_pkg::ENC1_RESOLVER): pair_ok = (e2 <= 2'(slm_pkg::ENC2_INCR));
			3'(slm_pkg::ENC1_SINCOS),
			3'(slm_pkg::ENC1_HIPER):    pair_ok = (e2 == 2'(slm_pkg::ENC2_NONE)) ||
			                                      (e2 == 2'(slm_pkg::ENC2_INCR));
			3'(slm_pkg::ENC1_OTHER):    pair_ok = (e2 == 2'(slm_pkg::ENC2_INCR));
			default:                    pair_ok = 1'b0;
		endcase
	endfunction : pair_ok

	// ----------------------------------------------------------------
	// state declarations
	// ----------------------------------------------------------------
	slm_pkg::slm_state_e state_q, state_d;
	logic [13:0] s1_q, s2_q, s3_q, pin_q, pin_d;
	logic [31:0] tmask_q [32];
	logic [31:0] tinv_q  [32];
	logic [31:0] vmap_q  [NV];
	logic [6:0]  lcfg_q  [NL];
	logic [8:0]  ctrl_q;
	logic [5:0]  enc_cfg_q;
	logic [3:0]  react_q;
	logic [31:0] lim_q, tol_q;
	logic [15:0] acc_q;
	logic [9:0]  drvm_q;
	logic [23:0] dly_q;
	logic [31:0] prdata_d, virtual_output_q, virtual_output_d, lin;
	logic [NV-1:0] virtual_control_input;
	logic [NL-1:0] logic_output_signal;
	logic [23:0] dcnt_q [4];
	logic [23:0] dcnt_d [4];
	logic [23:0] th_q, th_d, tick_q, tick_d, tp_q, tp_d;
	logic [23:0] tmr_q [4];
	logic [23:0] tmr_d [4];
	logic        th_out_q, th_out_d, qs_d, primed_q, primed_d;
	logic [3:0]  req_q, req_d, sferr_q, sferr_d, safe, err_q, err_d;
	logic [3:0]  disc_err;
	logic [15:0] p1_q, p2_q, sp1_q, rel1_q, rel2_q;
	logic [15:0] p1_d, p2_d, sp1_d, rel1_d, rel2_d, spd;
	logic        enc_err, cfg_ok, fatal, run, locked, mapped;
	logic        wr, cmd_commit, cmd_ack;
	logic [9:0]  word;
	slm_pkg::slm_drv_s drv_d;

	assign run    = (state_q == slm_pkg::ST_RUN);
	assign word   = paddr[11:2];
	assign wr     = psel & penable & pwrite;
	assign mapped = (paddr[11:2] <= 10'h00B) ||
	                (paddr >= `SLM_VMAP_BASE && paddr < `SLM_VMAP_BASE + 12'h040) ||
	                (paddr >= `SLM_LCFG_BASE && paddr < `SLM_LCFG_BASE + 12'h014) ||
	                (paddr >= `SLM_TERM_BASE && paddr < `SLM_TERM_BASE + 12'h100);
	assign locked = run && ({paddr[11:2], 2'b00} != `SLM_CTRL);
	assign cmd_commit = wr & (paddr == `SLM_CTRL) & pwdata[`SLM_CTRL_COMMIT];
	assign cmd_ack    = wr & (paddr == `SLM_CTRL) & pwdata[`SLM_CTRL_ACK];
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (~mapped | (pwrite & locked));

	// ----------------------------------------------------------------
	// pin synchroniser and two-channel checks
	// ----------------------------------------------------------------
	always_comb begin
		pin_d = (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		for (int i = 0; i < 4; i++) begin
			// level must match the type; a lasting mismatch is a fault
			if (pin_q[i] ^ pin_q[4+i] ^ ctrl_q[`SLM_CTRL_ANTI_LO+i]) begin
				dcnt_d[i]   = sinc(dcnt_q[i]);
			end else begin
				dcnt_d[i]   = 24'h000000;
			end
			disc_err[i] = (dcnt_q[i] >= 24'(DISC_CYC));
		end
		// two-hand: both within the window; only a full release restarts the window
		th_d     = (lin[2] | lin[3]) ? sinc(th_q) : 24'h000000;
		th_out_d = th_out_q ? (lin[2] & lin[3])
		                    : (lin[2] & lin[3] & (th_q < 24'(TWO_HAND_CYC)));
	end

	always_comb begin
		lin = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			lin[i] = pin_q[i] & (dcnt_q[i] == 24'h000000);
		end
		lin[9:4]   = pin_q[13:8];
		lin[12:10] = (ones({29'h0, pin_q[10:8]}) == 6'h01) ? pin_q[10:8] : 3'b000;
		lin[13]    = th_out_q;
		lin[17:14] = virtual_output_q[7:4];
		lin[25:18] = virtual_output_q[19:12];
		lin[26]    = run;
	end

	// ----------------------------------------------------------------
	// product term pool
	// ----------------------------------------------------------------
	always_comb begin
		logic [6:0] slots;
		logic       ok;
		slots = 7'h00;
		ok    = 1'b1;
		for (int v = 0; v < NV; v++) begin
			virtual_control_input[v] = 1'b0;
			for (int s = 0; s < 4; s++) begin
				if (vmap_q[v][8*s+`SLM_SLOT_VALID]) begin
					virtual_control_input[v] = virtual_control_input[v] | pterm(tmask_q[vmap_q[v][8*s +: 5]],
						tinv_q[vmap_q[v][8*s +: 5]], lin);
					slots  = 7'(slots + 7'h01);
					ok     = ok & (32'(vmap_q[v][8*s +: 5]) < TERMS);
				end
			end
		end
		for (int j = 0; j < NL; j++) begin
			logic_output_signal[j] = lcfg_q[j][`SLM_LCFG_VALID] &
				(pterm(tmask_q[lcfg_q[j][4:0]], tinv_q[lcfg_q[j][4:0]], virtual_output_q)
				^ lcfg_q[j][`SLM_LCFG_INV]);
			if (lcfg_q[j][`SLM_LCFG_VALID]) begin
				slots = 7'(slots + 7'h01);
				ok    = ok & (32'(lcfg_q[j][4:0]) < TERMS);
			end
		end
		for (int t = 0; t < 32; t++) begin
			ok = ok & (ones(tmask_q[t]) <= 6'(`SLM_TERM_INPUTS));
		end
		cfg_ok = ok & (32'(slots) <= TERMS) & pair_ok(enc_cfg_q);
	end

	// ----------------------------------------------------------------
	// encoder evaluation, relative only
	// ----------------------------------------------------------------
	always_comb begin
		logic [15:0] d1, d2;
		logic        tick, two;
		d1      = 16'(enc.pos1 - p1_q);
		d2      = 16'(enc.pos2 - p2_q);
		tick    = (tick_q == 24'(SAMPLE_CYC - 1));
		two     = (enc_cfg_q[5:4] != 2'(slm_pkg::ENC2_NONE));
		tick_d  = tick ? 24'h000000 : 24'(tick_q + 24'h000001);
		p1_d    = tick ? enc.pos1 : p1_q;
		p2_d    = tick ? enc.pos2 : p2_q;
		sp1_d   = (tick & run) ? d1 : (run ? sp1_q : 16'h0000);
		rel1_d  = run ? (tick ? 16'(rel1_q + d1) : rel1_q) : 16'h0000;
		rel2_d  = run ? (tick ? 16'(rel2_q + d2) : rel2_q) : 16'h0000;
		primed_d = run & (primed_q | tick);
		enc_err = tick & run & primed_q & (
			(two & (mag(16'(d1 - d2)) > tol_q[31:16])) |
			(two & (mag(16'(rel1_q - rel2_q)) > tol_q[15:0])) |
			(mag(16'(rel1_q - enc.peer_rel)) > tol_q[15:0]) |
			(ctrl_q[`SLM_CTRL_ACC_EN] & (mag(16'(d1 - sp1_q)) > acc_q)));
		spd     = mag(sp1_q);
	end

	// ----------------------------------------------------------------
	// safety functions
	// ----------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			// request wins over terminate in the same cycle
			req_d[k] = run & (virtual_control_input[2*k] | (req_q[k] & ~virtual_control_input[2*k+1]));
			tmr_d[k] = req_q[k] ? sinc(tmr_q[k]) : 24'h000000;
		end
		safe[0] = req_q[0];
		safe[1] = req_q[1] & (tmr_q[1] >= dly_q);
		safe[2] = req_q[2] & (spd <= lim_q[31:16]);
		safe[3] = req_q[3] & (spd <= lim_q[15:0]);
		sferr_d = sferr_q & ~{4{cmd_ack}};
		sferr_d[2] = sferr_d[2] | (req_q[2] & (tmr_q[2] >= dly_q) & ~safe[2]);
		sferr_d[3] = sferr_d[3] | (req_q[3] & (tmr_q[3] >= dly_q) & ~safe[3]);
		qs_d = req_q[1] & ~safe[1];
	end

	// ----------------------------------------------------------------
	// error handling and operating state
	// ----------------------------------------------------------------
	always_comb begin
		// new events win over the acknowledge
		err_d    = (err_q & ~{4{cmd_ack}}) |
		           {cmd_commit & (state_q == slm_pkg::ST_CONFIG) & ~cfg_ok,
		            run & (|disc_err), enc_err, run & (|sferr_q)};
		fatal    = |(err_q & {1'b1, react_q[2:0]});
		state_d  = state_q;
		case (state_q)
			slm_pkg::ST_INIT:   state_d = slm_pkg::ST_CONFIG;
			slm_pkg::ST_CONFIG: if (cmd_commit) begin
				state_d = cfg_ok ? slm_pkg::ST_RUN : slm_pkg::ST_ERROR;
			end
			slm_pkg::ST_RUN:    if (fatal) begin
				state_d = slm_pkg::ST_ERROR;
			end
			slm_pkg::ST_ERROR:  if (cmd_ack) begin
				state_d = slm_pkg::ST_CONFIG;
			end
			default:            state_d = slm_pkg::ST_INIT;
		endcase
		virtual_output_d        = 32'h00000000;
		virtual_output_d[3:0]   = req_q;
		virtual_output_d[7:4]   = safe;
		virtual_output_d[11:8]  = sferr_q;
		virtual_output_d[NV+3:12] = virtual_control_input[NV-1:8];
		virtual_output_d[21:20] = state_q;
		virtual_output_d[22]    = fatal;
		virtual_output_d[23]    = qs_d;
	end

	// ----------------------------------------------------------------
	// output drivers
	// ----------------------------------------------------------------
	always_comb begin
		logic on, pulse, torque_off;
		on    = 1'b0;
		tp_d  = (tp_q == 24'(TP_PERIOD_CYC - 1)) ? 24'h000000 : 24'(tp_q + 24'h000001);
		pulse = (tp_q < 24'(TPW_CYC));
		torque_off = ~run | fatal | req_q[0] | safe[1];
		for (int j = 0; j < NL; j++) begin
			// index 3 brake, 4 driver supply; both cut on request 0 at once, on request 1 once the stop delay has run out
			on = logic_output_signal[j] & run & ~fatal & ~((j >= 3) & torque_off);
			case (drvm_q[2*j +: 2])
				2'(slm_pkg::DRV_EQUIV): {drv_d.a[j], drv_d.b[j]} = {on, on};
				2'(slm_pkg::DRV_ANTI):  {drv_d.a[j], drv_d.b[j]} = {on, ~on & run};
				2'(slm_pkg::DRV_PULSE): {drv_d.a[j], drv_d.b[j]} = {2{on & ~pulse}};
				default:                {drv_d.a[j], drv_d.b[j]} = 2'b00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// apb read data, taken in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		prdata_d = 32'h00000000;
		if (!mapped) begin
			// holes above the term table must not alias onto it
			prdata_d = 32'h00000000;
		end else if (paddr >= `SLM_TERM_BASE) begin
			prdata_d = paddr[2] ? tinv_q[paddr[7:3]] : tmask_q[paddr[7:3]];
		end else if (paddr >= `SLM_LCFG_BASE) begin
			if (paddr < `SLM_LCFG_BASE + 12'h014) prdata_d = {25'h0, lcfg_q[paddr[4:2]]};
		end else if (paddr >= `SLM_VMAP_BASE) begin
			prdata_d = vmap_q[paddr[5:2]];
		end else begin
			case ({word, 2'b00})
				`SLM_CTRL:       prdata_d = {23'h0, ctrl_q};
				`SLM_STATUS:     prdata_d = {23'h0, cfg_ok, err_q, 2'b00, state_q};
				`SLM_VIN_STATE:  prdata_d = {16'h0, virtual_control_input};
				`SLM_VIRTUAL_OUTPUT_STATE: prdata_d = virtual_output_q;
				`SLM_ENC_CFG:    prdata_d = {26'h0, enc_cfg_q};
				`SLM_ERR_REACT:  prdata_d = {28'h0, react_q};
				`SLM_LIN_STATE:  prdata_d = lin;
				`SLM_SPD_LIMIT:  prdata_d = lim_q;
				`SLM_TOLERANCE:  prdata_d = tol_q;
				`SLM_ACC_LIMIT:  prdata_d = {16'h0, acc_q};
				`SLM_DRV_MODE:   prdata_d = {22'h0, drvm_q};
				`SLM_STOP_DELAY: prdata_d = {8'h0, dly_q};
				default:         prdata_d = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers, writable outside run only; the control word also in run
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < 32; t++) begin
				tmask_q[t] <= `SLM_RST_ZERO;
				tinv_q[t]  <= `SLM_RST_ZERO;
			end
			for (int v = 0; v < NV; v++) vmap_q[v] <= `SLM_RST_ZERO;
			for (int j = 0; j < NL; j++) lcfg_q[j] <= 7'h00;
			ctrl_q    <= 9'h000;
			enc_cfg_q <= 6'h00;
			react_q   <= `SLM_RST_REACT;
			lim_q     <= `SLM_RST_ZERO;
			tol_q     <= `SLM_RST_ZERO;
			acc_q     <= 16'h0000;
			drvm_q    <= 10'h000;
			dly_q     <= 24'h000000;
		end else if (wr & mapped & ~locked) begin
			if (paddr >= `SLM_TERM_BASE) begin
				if (paddr[2]) tinv_q[paddr[7:3]] <= pwdata;
				else tmask_q[paddr[7:3]] <= pwdata;
			end else if (paddr >= `SLM_LCFG_BASE) begin
				lcfg_q[paddr[4:2]] <= pwdata[6:0];
			end else if (paddr >= `SLM_VMAP_BASE) begin
				vmap_q[paddr[5:2]] <= pwdata;
			end else begin
				case ({word, 2'b00})
					`SLM_CTRL:       ctrl_q    <= {pwdata[8:4], 4'h0};
					`SLM_ENC_CFG:    enc_cfg_q <= pwdata[5:0];
					`SLM_ERR_REACT:  react_q   <= pwdata[3:0];
					`SLM_SPD_LIMIT:  lim_q     <= pwdata;
					`SLM_TOLERANCE:  tol_q     <= pwdata;
					`SLM_ACC_LIMIT:  acc_q     <= pwdata[15:0];
					`SLM_DRV_MODE:   drvm_q    <= pwdata[9:0];
					`SLM_STOP_DELAY: dly_q     <= pwdata[23:0];
					default:         dly_q     <= dly_q;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// working state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= slm_pkg::ST_INIT;
			s1_q     <= 14'h0000;
			s2_q     <= 14'h0000;
			s3_q     <= 14'h0000;
			pin_q    <= 14'h0000;
			for (int i = 0; i < 4; i++) begin
				dcnt_q[i] <= 24'h000000;
				tmr_q[i]  <= 24'h000000;
			end
			th_q     <= 24'h000000;
			th_out_q <= 1'b0;
			tick_q   <= 24'h000000;
			tp_q     <= 24'h000000;
			p1_q     <= 16'h0000;
			p2_q     <= 16'h0000;
			sp1_q    <= 16'h0000;
			rel1_q   <= 16'h0000;
			rel2_q   <= 16'h0000;
			primed_q <= 1'b0;
			req_q    <= 4'h0;
			sferr_q  <= 4'h0;
			err_q    <= 4'h0;
			virtual_output_q   <= `SLM_RST_ZERO;
			prdata   <= `SLM_RST_ZERO;
			drv      <= '0;
			quick_stop <= 1'b0;
			led_red  <= 1'b0;
			led_green <= 1'b0;
		end else begin
			state_q  <= state_d;
			s1_q     <= {din1, din2_b, din2_a};
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			pin_q    <= pin_d;
			dcnt_q   <= dcnt_d;
			tmr_q    <= tmr_d;
			th_q     <= th_d;
			th_out_q <= th_out_d;
			tick_q   <= tick_d;
			tp_q     <= tp_d;
			p1_q     <= p1_d;
			p2_q     <= p2_d;
			sp1_q    <= sp1_d;
			rel1_q   <= rel1_d;
			rel2_q   <= rel2_d;
			primed_q <= primed_d;
			req_q    <= req_d;
			sferr_q  <= sferr_d;
			err_q    <= err_d;
			virtual_output_q   <= virtual_output_d;
			if (psel & ~penable) prdata <= prdata_d;
			drv      <= drv_d;
			quick_stop <= qs_d;
			led_green <= (state_d == slm_pkg::ST_RUN) |
			             (state_d == slm_pkg::ST_CONFIG);
			led_red   <= (state_d == slm_pkg::ST_ERROR) |
			             (state_d == slm_pkg::ST_CONFIG);
		end
	end
endmodule : slm_core

// ### design/slm_consts.svh
// constants of the safety logic matrix: offsets, fields, reset values, times
// assumes a single 25 MHz module clock; included by bare name
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SLM_CLK_HZ        25000000
`define SLM_TWO_HAND_MS   500
`define SLM_DISC_MS       10
`define SLM_SAMPLE_US     1000
`define SLM_TP_PERIOD_US  1000
`define SLM_TP_WIDTH_US   1
// ----------------------------------------------------------------
// logic pool
// ----------------------------------------------------------------
`define SLM_POOL_TERMS    32
`define SLM_TERM_INPUTS   7
`define SLM_NUM_VIRT      16
`define SLM_NUM_LOGIC_OUTPUT_SIGNAL      5
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SLM_CTRL          12'h000
`define SLM_STATUS        12'h004
`define SLM_VIN_STATE     12'h008
`define SLM_VIRTUAL_OUTPUT_STATE    12'h00C
`define SLM_ENC_CFG       12'h010
`define SLM_ERR_REACT     12'h014
`define SLM_LIN_STATE     12'h018
`define SLM_SPD_LIMIT     12'h01C
`define SLM_TOLERANCE     12'h020
`define SLM_ACC_LIMIT     12'h024
`define SLM_DRV_MODE      12'h028
`define SLM_STOP_DELAY    12'h02C
`define SLM_VMAP_BASE     12'h040
`define SLM_LCFG_BASE     12'h080
`define SLM_TERM_BASE     12'h100
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SLM_CTRL_COMMIT   0
`define SLM_CTRL_ACK      1
`define SLM_CTRL_ANTI_LO  4
`define SLM_CTRL_ACC_EN   8
`define SLM_SLOT_VALID    7
`define SLM_LCFG_VALID    5
`define SLM_LCFG_INV      6
`define SLM_RST_ZERO      32'h00000000
`define SLM_RST_REACT     4'hF
`endif

// ### design/slm_pkg.sv
// types of the safety logic matrix
// assumes slm_consts.svh for all numeric constants
package slm_pkg;
	// ----------------------------------------------------------------
	// state and modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_INIT,
		ST_CONFIG,
		ST_RUN,
		ST_ERROR
	} slm_state_e;
	typedef enum logic [1:0] {
		DRV_EQUIV,
		DRV_ANTI,
		DRV_PULSE,
		DRV_OFF
	} slm_drv_e;
	typedef enum logic [2:0] {
		ENC1_RESOLVER,
		ENC1_SINCOS,
		ENC1_HIPER,
		ENC1_SERIAL,
		ENC1_OTHER
	} slm_enc1_e;
	typedef enum logic [1:0] {
		ENC2_NONE,
		ENC2_OTHER,
		ENC2_INCR
	} slm_enc2_e;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] pos1;
		logic [15:0] pos2;
		logic [15:0] peer_rel;
	} slm_enc_s;
	typedef struct packed {
		logic [4:0] a;
		logic [4:0] b;
	} slm_drv_s;
endpackage : slm_pkg

// ### test/slm_core_assertions.sv
// checker: bus and state relations of the safety logic matrix core
// assumes only the core's ports; bound to every slm_core below
module slm_chk (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire slm_pkg::slm_drv_s drv,
	input wire logic              led_red,
	input wire logic              led_green
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready)
		else $error("pready low");
	property p_idle; !acc |-> !pslverr; endproperty
	a_idle: assert property (p_idle)
		else $error("pslverr outside access");
	property p_unmap; acc && paddr == 12'hFFC |-> pslverr; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access not refused");
	property p_unmap_rd;
		acc && !pwrite && paddr == 12'hFFC |-> prdata == 32'h00000000;
	endproperty
	a_unmap_rd: assert property (p_unmap_rd)
		else $error("unmapped read not zero");
	property p_ctrl; acc && paddr == 12'h000 |-> !pslverr; endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control access refused");
	// led lags nothing on entry, so a settled run is asked for
	property p_lock;
		acc && pwrite && paddr == 12'h010 && led_green && !led_red
			&& $past(led_green) |-> pslverr;
	endproperty
	a_lock: assert property (p_lock)
		else $error("encoder setup accepted in run");
	property p_drv_off; (!led_green) [*3] |-> drv == '0; endproperty
	a_drv_off: assert property (p_drv_off)
		else $error("drivers active outside run");
	property p_led_cfg;
		$rose(presetn) |-> ##[0:2] (led_red && led_green);
	endproperty
	a_led_cfg: assert property (p_led_cfg)
		else $error("config indication missing after reset");
endmodule : slm_chk
bind slm_core slm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .drv(drv), .led_red(led_red),
	.led_green(led_green));

// ### test/slm_enc_model.sv
// partner: sensors and base unit feeding position words
// assumes one pclk domain; the shaft stands still
module slm_enc_model #(
	parameter logic [15:0] POS = 16'h1234 // arbitrary start count
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         fault,
	output slm_pkg::slm_enc_s enc
);
	// ----------------------------------------------------------------
	// position words
	// ----------------------------------------------------------------
	// both sensors read one shaft; a fault skews the second
	assign enc.pos1     = POS;
	assign enc.pos2     = POS + (fault ? 16'h0100 : 16'h0000);
	// peer channel sees no relative motion, only relative counts exist
	assign enc.peer_rel = 16'h0000;
endmodule : slm_enc_model

// ### test/slm_core_tb.sv
// testbench of the safety logic matrix core, self-checking
// assumes shortened counts through the core's parameters
module slm_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals and helpers
	// ----------------------------------------------------------------
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h00000000;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [3:0]        din2 = 4'h0;
	logic [3:0]        skew = 4'h0;
	logic [5:0]        din1 = 6'h00;
	logic              fault = 1'b0;
	slm_pkg::slm_enc_s enc;
	slm_pkg::slm_drv_s drv;
	int                n_mismatch = 0;
	int                compares = 0;
	logic [31:0]       rd;
	logic              err;
	logic [15:0]       lfsr_q = 16'h0008;
	logic [12:0]       lin;
	always #20 pclk = ~pclk;
	slm_core #(.TWO_HAND_CYC(50), .DISC_CYC(20), .SAMPLE_CYC(8),
		.TP_PERIOD_CYC(40)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .din2_a(din2), .din2_b(din2 ^ skew), .din1(din1),
		.enc(enc), .drv(drv), .quick_stop(), .led_red(), .led_green());
	slm_enc_model u_enc (.pclk(pclk), .presetn(presetn), .fault(fault),
		.enc(enc));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic bit pair_ok(input int e1, input int e2);
		return (e1 == 0) || ((e1 == 1 || e1 == 2) && e2 != 1)
			|| (e1 == 4 && e2 == 2);
	endfunction : pair_ok
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (i >= 16) begin
			n_mismatch++;
			conclude();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h00000000);
		chk(rd & m, e);
	endtask : rdchk
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		rdchk(12'h004, 32'h1, 32'h3);
		apb(1'b1, 12'h020, 32'h00100010);
		apb(1'b1, 12'h100, 32'h00000001);
		apb(1'b1, 12'h108, 32'h00000002);
		apb(1'b1, 12'h10C, 32'h00000002);
		apb(1'b1, 12'h040, 32'h00008180);
		apb(1'b1, 12'h080, 32'h00000022);
		apb(1'b1, 12'h010, 32'h00000020);
		apb(1'b1, 12'h000, 32'h00000001);
		rdchk(12'h004, 32'h2, 32'h3);
		chk({22'h0, drv}, 32'h00000021);
		apb(1'b1, 12'h010, 32'h00000001);
		chk({31'h0, err}, 32'h1);
		rdchk(12'h010, 32'h20, 32'h37);
		for (int k = 0; k < 8; k++) begin
			lfsr_q = lfsr(lfsr_q);
			din2 <= lfsr_q[3:0];
			din1 <= lfsr_q[9:4];
			repeat (8) @(posedge pclk);
			lin = {din1[2:0] & {3{$onehot(din1[2:0])}}, din1, din2};
			rdchk(12'h018, {19'h0, lin}, 32'h1FFF);
			rdchk(12'h008, {31'h0, lin[0] | ~lin[1]}, 32'h3);
		end
		// skew too large for the tolerance must stop the drive
		fault <= 1'b1;
		repeat (40) @(posedge pclk);
		rdchk(12'h004, 32'h23, 32'hF3);
		chk({22'h0, drv}, 32'h00000000);
		fault <= 1'b0;
		apb(1'b1, 12'h000, 32'h00000002);
		rdchk(12'h004, 32'h1, 32'h3);
		for (int e1 = 0; e1 < 5; e1++)
			for (int e2 = 0; e2 < 3; e2++) begin
				do_reset();
				apb(1'b1, 12'h010, 32'(e2 * 16 + e1));
				apb(1'b1, 12'h000, 32'h00000001);
				rdchk(12'h004, pair_ok(e1, e2) ? 32'h2 : 32'h3, 32'h3);
			end
		// 32 slots fit the pool, 36 do not
		for (int n = 8; n < 10; n++) begin
			do_reset();
			for (int v = 0; v < n; v++)
				apb(1'b1, 12'(64 + 4 * v), 32'h80808080);
			apb(1'b1, 12'h000, 32'h00000001);
			rdchk(12'h004, n == 8 ? 32'h2 : 32'h3, 32'h3);
		end
		// channels disagreeing longer than the window stop the drive
		do_reset();
		repeat (16) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h00000001);
		skew <= 4'h1;
		repeat (40) @(posedge pclk);
		rdchk(12'h004, 32'h43, 32'hF3);
		do_reset();
		apb(1'b1, 12'h100, 32'h000000FF);
		apb(1'b1, 12'h000, 32'h00000001);
		rdchk(12'h004, 32'h83, 32'h83);
		apb(1'b1, 12'h1FC, 32'hFFFFFFFF);
		apb(1'b0, 12'hFFC, 32'h00000000);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h00000000);
		conclude();
	end
endmodule : slm_core_tb
